// ---- hdl/adcsc_pkg.sv ----
/*
  Package for the converter sequencer: register offsets, field layouts,
  reset values, trigger encodings, states and conversion timing tables.
  Assumes one system clock; all timing figures are counted in its states.
*/
package adcsc_pkg;

  // Register byte offsets on the APB
  localparam logic [7:0] OFS_CSR   = 8'h00;
  localparam logic [7:0] OFS_MODE  = 8'h04;
  localparam logic [7:0] OFS_MSTOP = 8'h08;
  localparam logic [7:0] OFS_DATA  = 8'h40;   // 16 result words, 8'h40 to 8'h7C
  localparam int         NUM_CH    = 16;

  // Reset values
  localparam logic [7:0] CSR_RESET   = 8'h00;
  localparam logic [7:0] MODE_RESET  = 8'h00;
  localparam logic       MSTOP_RESET = 1'b1;

  // Trigger source encodings
  localparam logic [1:0] TRIG_NONE       = 2'h0;
  localparam logic [1:0] TRIG_PULSE_UNIT = 2'h1;
  localparam logic [1:0] TRIG_EIGHT_BIT  = 2'h2;
  localparam logic [1:0] TRIG_PIN        = 2'h3;

  // Control and status register, bits 7 down to 0
  typedef struct packed {
    logic       conv_end_flag;
    logic       conv_end_irq_enable;
    logic       conv_running;
    logic       rsvd;
    logic [3:0] chan_sel;
  } adcsc_csr_type;

  // Trigger and mode register, bits 7 down to 0
  typedef struct packed {
    logic [1:0] trig_sel;
    logic       scan_enable;
    logic       scan_size;
    logic [1:0] conv_clk_sel;
    logic [1:0] rsvd;
  } adcsc_mode_type;

  typedef enum logic [2:0] {ST_IDLE, ST_DELAY, ST_SAMPLE, ST_CONVERT, ST_GAP} adcsc_state_type;

  // Timing in states, indexed by the clock-select field
  localparam logic [9:0] TD_MIN   [4] = '{10'h012, 10'h00A, 10'h006, 10'h004};
  localparam logic [9:0] TD_MAX   [4] = '{10'h021, 10'h011, 10'h009, 10'h005};
  localparam logic [9:0] SPL      [4] = '{10'h07F, 10'h03F, 10'h01F, 10'h00F};
  localparam logic [9:0] CONV_MAX [4] = '{10'h212, 10'h10A, 10'h086, 10'h044};
  localparam logic [9:0] SCAN_T   [4] = '{10'h200, 10'h100, 10'h080, 10'h040};
  localparam logic [9:0] SAR_BITS = 10'h00A;

  // Sampling plus approximation, the part after the start delay
  function automatic logic [9:0] adcsc_body(input logic [1:0] k);
    return CONV_MAX[k] - TD_MAX[k];
  endfunction

  function automatic logic [9:0] adcsc_conv(input logic [1:0] k);
    return adcsc_body(k) - SPL[k];
  endfunction

  // Pause between scan conversions, so each later one takes the fixed period
  function automatic logic [9:0] adcsc_gap(input logic [1:0] k);
    return SCAN_T[k] - adcsc_body(k);
  endfunction

  function automatic logic [9:0] adcsc_step(input logic [1:0] k);
    return adcsc_conv(k) / SAR_BITS;
  endfunction

endpackage

// ---- hdl/adcsc_top.sv ----
/*
  Converter sequencer: APB register slave, single and scan sequencing,
  trigger selection, start-delay and sampling timing, successive
  approximation control and result storage.
  Assumes an analog macro outside: it samples while sample_hold is high on
  channel analog_chan and drives cmp_in high when the input is at or above
  the level set by sar_dac, settled within one approximation step; the first
  step is one state shorter so the last bit lands before the result is stored.
*/
`timescale 1ns/100ps
module adcsc_top
  import adcsc_pkg::*;
#(
  parameter int RES = 10
) (
  input  wire logic            pclk,
  input  wire logic            presetn,
  input  wire logic            ce,
  input  wire logic            psel,
  input  wire logic            penable,
  input  wire logic            pwrite,
  input  wire logic [7:0]      paddr,
  input  wire logic [31:0]     pwdata,
  output logic      [31:0]     prdata,
  output logic                 pready,
  output logic                 pslverr,
  input  wire logic            cmp_in,
  input  wire logic            timer_pulse_unit_trig,
  input  wire logic            eight_bit_timer_trig,
  input  wire logic            ext_trigger_pin,
  output logic                 sample_hold,
  output logic      [3:0]      analog_chan,
  output logic      [RES-1:0]  sar_dac,
  output logic                 conv_end_irq
);

  adcsc_csr_type   csr;
  adcsc_csr_type   next_csr;
  adcsc_csr_type   wcsr;
  adcsc_mode_type  mode;
  adcsc_state_type st;
  logic            mstop;
  logic [RES-1:0]  data_reg [NUM_CH];
  logic [9:0]      cnt;
  logic [9:0]      stp;
  logic [3:0]      bidx;
  logic            sar_busy;
  logic [3:0]      psc;
  logic            pin_s1;
  logic            pin_s2;
  logic            pin_s3;
  logic            pin_lvl;
  logic            pin_fall;
  logic            trig_start;
  logic            apb_done;
  logic            wr_csr;
  logic            conv_done;
  logic            is_last;
  logic            set_flag;
  logic            single_end;
  logic [1:0]      k;
  logic [3:0]      first_ch;
  logic [3:0]      last_ch;
  logic [9:0]      td_load;
  logic [31:0]     rd_val;
  logic            rd_err;

  assign wcsr = adcsc_csr_type'(pwdata[7:0]);
  assign k    = mode.conv_clk_sel;

  // APB answer: one wait state, write lands on the completing edge
  assign apb_done = psel && penable && pready;
  assign wr_csr   = apb_done && pwrite && !mstop && (paddr == OFS_CSR);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      prdata  <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else if (ce) begin
      pready  <= psel && penable && !pready;
      prdata  <= (psel && penable && !pready && !pwrite) ? rd_val : 32'h0000_0000;
      pslverr <= psel && penable && !pready && rd_err;
    end
  end

  // Read decode; stopped module answers with an error and zero data, except at the module stop register
  always_comb begin
    rd_val = 32'h0000_0000;
    rd_err = 1'b0;
    if (paddr == OFS_MSTOP) begin
      rd_val[0] = mstop;
    end else if (mstop) begin
      rd_err = 1'b1;
    end else if (paddr == OFS_CSR) begin
      rd_val[7:0] = csr;
    end else if (paddr == OFS_MODE) begin
      rd_val[7:0] = mode;
    end else if (paddr[7:6] == OFS_DATA[7:6] && paddr[1:0] == 2'h0) begin
      rd_val[RES-1:0] = data_reg[paddr[5:2]];
    end else begin
      rd_err = 1'b1;
    end
  end

  // Module stop and mode registers; reserved mode bits stay zero
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mstop <= MSTOP_RESET;
      mode  <= adcsc_mode_type'(MODE_RESET);
    end else if (ce && apb_done && pwrite) begin
      if (paddr == OFS_MSTOP) begin
        mstop <= pwdata[0];
      end
      if (!mstop && paddr == OFS_MODE) begin
        mode <= adcsc_mode_type'({pwdata[7:2], 2'h0});
      end
    end
  end

  // External pin: three flops, a level counts once stages two and three agree
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_s1  <= 1'b1;
      pin_s2  <= 1'b1;
      pin_s3  <= 1'b1;
      pin_lvl <= 1'b1;
    end else if (ce) begin
      pin_s1 <= ext_trigger_pin;
      pin_s2 <= pin_s1;
      pin_s3 <= pin_s2;
      if (pin_s2 == pin_s3) begin
        pin_lvl <= pin_s2;
      end
    end
  end

  assign pin_fall = pin_lvl && (pin_s2 == pin_s3) && !pin_s2;

  always_comb begin
    unique case (mode.trig_sel)
      TRIG_NONE:       trig_start = 1'b0;
      TRIG_PULSE_UNIT: trig_start = timer_pulse_unit_trig;
      TRIG_EIGHT_BIT:  trig_start = eight_bit_timer_trig;
      TRIG_PIN:        trig_start = pin_fall;
    endcase
  end

  // group bounds, four-channel start, eight-channel start
  always_comb begin
    if (mode.scan_size) begin
      first_ch = {csr.chan_sel[3], 3'h0};
      last_ch  = csr.chan_sel;
    end else begin
      first_ch = {csr.chan_sel[3:2], 2'h0};
      last_ch  = csr.chan_sel;
    end
  end

  assign is_last    = (analog_chan == last_ch);
  assign conv_done  = ce && csr.conv_running && (st == ST_CONVERT) && (cnt == 10'h000);
  assign single_end = conv_done && !mode.scan_enable;
  // flag after each single conversion, in scan only after the group's last channel
  assign set_flag   = conv_done && (!mode.scan_enable || is_last);

  // Control register next value; hardware sets win over software clears
  always_comb begin
    next_csr = csr;
    if (single_end) begin
      next_csr.conv_running = 1'b0;
    end
    if (wr_csr) begin
      next_csr.conv_end_irq_enable = wcsr.conv_end_irq_enable;
      next_csr.chan_sel            = wcsr.chan_sel;
      next_csr.conv_running        = wcsr.conv_running;
      if (!wcsr.conv_end_flag) begin
        next_csr.conv_end_flag = 1'b0;
      end
    end
    // trigger sets running, same path as software
    if (trig_start) begin
      next_csr.conv_running = 1'b1;
    end
    if (set_flag) begin
      next_csr.conv_end_flag = 1'b1;
    end
    if (mstop) begin
      next_csr.conv_running = 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      csr          <= adcsc_csr_type'(CSR_RESET);
      conv_end_irq <= 1'b0;
    end else if (ce) begin
      csr          <= next_csr;
      // level from flag and enable, drops with either
      conv_end_irq <= next_csr.conv_end_flag && next_csr.conv_end_irq_enable;
    end
  end

  // Free phase counter; the write lands at a random phase of it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      psc <= 4'h0;
    end else if (ce) begin
      psc <= psc + 4'h1;
    end
  end

  // start delay from phase, counted from the start edge
  assign td_load = TD_MIN[k] + ({6'h00, psc} & (TD_MAX[k] - TD_MIN[k])) - 10'h002;

  // Sequencer: delay, sample, approximate, then idle or next channel
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st          <= ST_IDLE;
      cnt         <= 10'h000;
      stp         <= 10'h000;
      bidx        <= 4'h0;
      sar_busy    <= 1'b0;
      sar_dac     <= '0;
      sample_hold <= 1'b0;
      analog_chan <= 4'h0;
    end else if (ce) begin
      if (!csr.conv_running) begin
        st          <= ST_IDLE;
        sample_hold <= 1'b0;
        sar_busy    <= 1'b0;
      end else begin
        unique case (st)
          // start, channel and delay taken with the start, scan from first
          ST_IDLE: begin
            st          <= ST_DELAY;
            cnt         <= td_load;
            analog_chan <= mode.scan_enable ? first_ch : csr.chan_sel;
          end
          ST_DELAY: begin
            if (cnt == 10'h000) begin
              st          <= ST_SAMPLE;
              cnt         <= SPL[k] - 10'h001;
              sample_hold <= 1'b1;
            end else begin
              cnt <= cnt - 10'h001;
            end
          end
          ST_SAMPLE: begin
            if (cnt == 10'h000) begin
              st          <= ST_CONVERT;
              cnt         <= adcsc_conv(k) - 10'h001;
              sample_hold <= 1'b0;
              sar_dac     <= {1'b1, {(RES-1){1'b0}}};
              bidx        <= 4'(RES - 1);
              // First step one short: at the slowest clock the last bit would meet the store
              stp         <= adcsc_step(k) - 10'h002;
              sar_busy    <= 1'b1;
            end else begin
              cnt <= cnt - 10'h001;
            end
          end
          ST_CONVERT: begin
            cnt <= cnt - 10'h001;
            if (sar_busy) begin
              if (stp == 10'h000) begin
                sar_dac[bidx] <= cmp_in;
                stp           <= adcsc_step(k) - 10'h001;
                if (bidx == 4'h0) begin
                  sar_busy <= 1'b0;
                end else begin
                  sar_dac[4'(bidx - 4'h1)] <= 1'b1;
                  bidx                     <= bidx - 4'h1;
                end
              end else begin
                stp <= stp - 10'h001;
              end
            end
            if (cnt == 10'h000) begin
              if (mode.scan_enable) begin
                // pause keeps the scan period fixed, wrap to first
                st          <= ST_GAP;
                cnt         <= adcsc_gap(k) - 10'h001;
                analog_chan <= is_last ? first_ch : analog_chan + 4'h1;
              end else begin
                st <= ST_IDLE;
              end
            end
          end
          ST_GAP: begin
            if (cnt == 10'h000) begin
              st          <= ST_SAMPLE;
              cnt         <= SPL[k] - 10'h001;
              sample_hold <= 1'b1;
            end else begin
              cnt <= cnt - 10'h001;
            end
          end
        endcase
      end
    end
  end

  // single result store, scan results in channel order
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < NUM_CH; i++) begin
        data_reg[i] <= '0;
      end
    end else if (conv_done) begin
      data_reg[analog_chan] <= sar_dac;
    end
  end

  // Helper: states between scan conversion ends
  logic [9:0] per_cnt;
  logic       prev_scan;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      per_cnt   <= 10'h000;
      prev_scan <= 1'b0;
    end else if (ce) begin
      per_cnt   <= conv_done ? 10'h000 : per_cnt + 10'h001;
      prev_scan <= (st == ST_IDLE) ? 1'b0 : (conv_done ? mode.scan_enable : prev_scan);
    end
  end

  sequence s_pin_fall;
    ce && !mstop && mode.trig_sel == TRIG_PIN && pin_fall;
  endsequence

  sequence s_running_next;
    ##1 csr.conv_running;
  endsequence

  property p_single_autoclear;
    @(posedge pclk) disable iff (!presetn)
    single_end && !trig_start && !(wr_csr && wcsr.conv_running) |=> !csr.conv_running;
  endproperty
  a_single_autoclear: assert property (p_single_autoclear) else $error("running not cleared");

  property p_flag_on_end;
    @(posedge pclk) disable iff (!presetn)
    set_flag |=> csr.conv_end_flag;
  endproperty
  a_flag_on_end: assert property (p_flag_on_end) else $error("end flag not set");

  property p_irq_level;
    @(posedge pclk) disable iff (!presetn)
    conv_end_irq == (csr.conv_end_flag && csr.conv_end_irq_enable);
  endproperty
  a_irq_level: assert property (p_irq_level) else $error("irq level mismatch");

  property p_abort;
    @(posedge pclk) disable iff (!presetn)
    ce && st != ST_IDLE && !csr.conv_running |=> st == ST_IDLE && !sample_hold;
  endproperty
  a_abort: assert property (p_abort) else $error("abort ignored");

  property p_store;
    @(posedge pclk) disable iff (!presetn)
    conv_done |=> data_reg[$past(analog_chan)] == $past(sar_dac);
  endproperty
  a_store: assert property (p_store) else $error("result not stored");

  property p_scan_runs;
    @(posedge pclk) disable iff (!presetn)
    conv_done && mode.scan_enable && !mstop && !wr_csr |=> csr.conv_running && st == ST_GAP;
  endproperty
  a_scan_runs: assert property (p_scan_runs) else $error("scan stopped");

  property p_ext_trig;
    @(posedge pclk) disable iff (!presetn)
    s_pin_fall |-> s_running_next;
  endproperty
  a_ext_trig: assert property (p_ext_trig) else $error("pin trigger lost");

  property p_delay_range;
    @(posedge pclk) disable iff (!presetn)
    ce && st == ST_IDLE && csr.conv_running |=>
      st == ST_DELAY && cnt >= $past(TD_MIN[k]) - 10'h002 && cnt <= $past(TD_MAX[k]) - 10'h002;
  endproperty
  a_delay_range: assert property (p_delay_range) else $error("start delay out of range");

  property p_scan_period;
    @(posedge pclk) disable iff (!presetn)
    conv_done && prev_scan |-> per_cnt == SCAN_T[k] - 10'h001;
  endproperty
  a_scan_period: assert property (p_scan_period) else $error("scan period wrong");

  property p_sample_len;
    @(posedge pclk) disable iff (!presetn)
    $rose(sample_hold) |-> cnt == SPL[k] - 10'h001;
  endproperty
  a_sample_len: assert property (p_sample_len) else $error("sampling length wrong");

  property p_first_chan;
    @(posedge pclk) disable iff (!presetn)
    ce && st == ST_IDLE && csr.conv_running && mode.scan_enable |=> analog_chan == $past(first_ch);
  endproperty
  a_first_chan: assert property (p_first_chan) else $error("scan start channel wrong");

  property p_flag_write_one;
    @(posedge pclk) disable iff (!presetn)
    ce && !csr.conv_end_flag && !set_flag |=> !csr.conv_end_flag;
  endproperty
  a_flag_write_one: assert property (p_flag_write_one) else $error("flag set by write");

  property p_mstop_idle;
    @(posedge pclk) disable iff (!presetn)
    ce && mstop |=> !csr.conv_running;
  endproperty
  a_mstop_idle: assert property (p_mstop_idle) else $error("runs while stopped");

endmodule // adcsc_top

// ---- verif/adcsc_analog_model.sv ----
/*
  Behavioural analog macro for the converter sequencer: one fixed level per
  channel, tracked while sampling and held afterwards for the comparator.
  Assumes sample_hold, analog_chan and sar_dac are driven on pclk.
*/
`timescale 1ns/100ps
module adcsc_analog_model (
  input  wire logic       pclk,
  input  wire logic       sample_hold,
  input  wire logic [3:0] analog_chan,
  input  wire logic [9:0] sar_dac,
  output logic            cmp_in
);
  logic [9:0] held;

  // Level ramp, both end codes appear on channels 0 and 15
  function automatic logic [9:0] level(input logic [3:0] c);
    return (c == 4'hF) ? 10'h3FF : 10'(c) * 10'h043;
  endfunction

  // Hold follows the input only in the window, like a real capacitor
  always_ff @(posedge pclk) begin
    if (sample_hold)
      held <= level(analog_chan);
  end

  assign cmp_in = (held >= sar_dac);
endmodule // adcsc_analog_model

// ---- verif/adc_sequencer_control_bench.sv ----
/*
  Self-checking bench for the converter sequencer: APB register tasks,
  single, abort, scan and trigger sequences with computed expectations.
  Assumes the sequencer package and the analog macro model.
*/
`timescale 1ns/100ps
module adc_sequencer_control_bench;
  import adcsc_pkg::*;
  logic pclk = 1'b0, presetn = 1'b0, ce = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic timer_pulse_unit_trig = 1'b0, eight_bit_timer_trig = 1'b0, ext_trigger_pin = 1'b1;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd_v;
  logic        pready, pslverr, cmp_in, sample_hold, conv_end_irq, rd_e, sh_d;
  logic [3:0]  analog_chan;
  logic [9:0]  sar_dac;
  int          n_mismatch = 0, tests_run = 0, cyc = 0, sh_cnt = 0;
  int          q_ch[$], q_t[$];
  localparam int T_LO[4] = '{515, 259, 131, 67};
  localparam int T_HI[4] = '{530, 266, 134, 68};
  localparam int SPL_N[4] = '{127, 63, 31, 15};
  localparam int SCAN_N[4] = '{512, 256, 128, 64};

  adcsc_top #(.RES(10)) i_dut (.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .cmp_in(cmp_in), .timer_pulse_unit_trig(timer_pulse_unit_trig), .eight_bit_timer_trig(eight_bit_timer_trig),
    .ext_trigger_pin(ext_trigger_pin), .sample_hold(sample_hold), .analog_chan(analog_chan),
    .sar_dac(sar_dac), .conv_end_irq(conv_end_irq));
  adcsc_analog_model i_analog (.pclk(pclk), .sample_hold(sample_hold), .analog_chan(analog_chan),
    .sar_dac(sar_dac), .cmp_in(cmp_in));

  always #10 pclk = ~pclk;

  // Sampling window monitor: length and channel plus start time of each
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    sh_d <= sample_hold;
    if (sample_hold === 1'b1)
      sh_cnt <= sh_cnt + 1;
    if (sample_hold === 1'b1 && sh_d !== 1'b1) begin
      q_ch.push_back(int'(analog_chan));
      q_t.push_back(cyc);
    end
  end

  // Expected result, same ramp as the analog model
  function automatic logic [31:0] lvl(input int c);
    return (c == 15) ? 32'h3FF : 32'(c) * 32'h43;
  endfunction

  task automatic close_out;
    if (n_mismatch == 0 && tests_run > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    tests_run++;
    if (got !== exp) begin
      n_mismatch++;
      $display("mismatch %s expected %h seen %h", nm, exp, got);
    end
  endtask

  // One APB transfer; request held until pready is seen high
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1);
    // Slave answers in the second access cycle, one wait state
    chk("apb_wait", 32'h2, 32'(n));
    rd_v = prdata;
    rd_e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rdchk(input logic [7:0] a, input logic [31:0] exp, input logic err);
    apb(1'b0, a, 32'h0);
    chk("prdata", exp, rd_v);
    chk("pslverr", {31'h0, err}, {31'h0, rd_e});
  endtask

  // Bounded wait for the end interrupt, n is edges waited
  task automatic wait_end(output int n);
    n = 0;
    while (conv_end_irq !== 1'b1 && n < 6000) begin
      @(posedge pclk);
      n++;
    end
  endtask

  // Source 1 and 2 pulse one cycle; 3 drops the pin for a while
  task automatic fire(input int s);
    @(posedge pclk);
    if (s == 1)
      timer_pulse_unit_trig <= 1'b1;
    if (s == 2)
      eight_bit_timer_trig <= 1'b1;
    if (s == 3)
      ext_trigger_pin <= 1'b0;
    @(posedge pclk);
    timer_pulse_unit_trig <= 1'b0;
    eight_bit_timer_trig <= 1'b0;
    repeat (8) @(posedge pclk);
    ext_trigger_pin <= 1'b1;
  endtask

  // Watchdog, well beyond the longest scan sequence
  initial begin
    repeat (60000) @(posedge pclk);
    n_mismatch++;
    close_out();
  end

  initial begin
    int n, k, s, nc, st, gsz, g0, csel;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    // Module stop lets only its own register through
    rdchk(OFS_CSR, 32'h0, 1'b1);
    apb(1'b1, OFS_CSR, 32'h20);
    rdchk(OFS_MSTOP, 32'h1, 1'b0);
    apb(1'b1, OFS_MSTOP, 32'h0);
    rdchk(OFS_CSR, 32'h0, 1'b0);
    rdchk(OFS_MODE, 32'h0, 1'b0);
    rdchk(8'h20, 32'h0, 1'b1);
    apb(1'b1, OFS_DATA, 32'h3FF);
    rdchk(OFS_DATA, 32'h0, 1'b0);
    // Single conversions at every clock select, edge codes included
    for (k = 0; k < 4; k++) begin
      apb(1'b1, OFS_MODE, 32'({4'h0, 2'(k), 2'b00}));
      nc = k * 5;
      st = sh_cnt;
      apb(1'b1, OFS_CSR, 32'({4'h6, 4'(nc)}));
      wait_end(n);
      chk("conv_time", 32'h1, 32'(n - 1 >= T_LO[k] && n - 1 <= T_HI[k]));
      chk("sample_len", 32'(SPL_N[k]), 32'(sh_cnt - st));
      rdchk(OFS_CSR, 32'({4'hC, 4'(nc)}), 1'b0);
      rdchk(OFS_DATA + 8'(4 * nc), lvl(nc), 1'b0);
      apb(1'b1, OFS_CSR, 32'({4'h8, 4'(nc)}));
      @(posedge pclk);
      chk("irq", 32'h0, {31'h0, conv_end_irq});
      rdchk(OFS_CSR, 32'({4'h8, 4'(nc)}), 1'b0);
      apb(1'b1, OFS_CSR, 32'({4'hC, 4'(nc)}));
      @(posedge pclk);
      chk("irq", 32'h1, {31'h0, conv_end_irq});
      apb(1'b1, OFS_CSR, 32'({4'h4, 4'(nc)}));
      @(posedge pclk);
      chk("irq", 32'h0, {31'h0, conv_end_irq});
    end
    // Abort in the middle of sampling
    apb(1'b1, OFS_MODE, 32'h0);
    apb(1'b1, OFS_CSR, 32'h23);
    repeat (60) @(posedge pclk);
    apb(1'b1, OFS_CSR, 32'h03);
    repeat (600) @(posedge pclk);
    rdchk(OFS_CSR, 32'h03, 1'b0);
    rdchk(OFS_DATA + 8'h0C, 32'h0, 1'b0);
    chk("sample_hold", 32'h0, {31'h0, sample_hold});
    // Scan_size: four-channel groups at each start, then both eight groups
    for (s = 0; s < 6; s++) begin
      gsz = (s < 4) ? 4 : 8;
      g0 = (s < 4) ? 4 * s : 8 * (s - 4);
      csel = g0 + gsz - 1;
      apb(1'b1, OFS_MODE, 32'({2'b00, 1'b1, s > 3, 2'(s % 4), 2'b00}));
      q_ch.delete();
      q_t.delete();
      apb(1'b1, OFS_CSR, 32'({4'h6, 4'(csel)}));
      n = 0;
      while (q_ch.size() < gsz + 2 && n < 6000) begin
        @(posedge pclk);
        n++;
      end
      rdchk(OFS_CSR, 32'({4'hE, 4'(csel)}), 1'b0);
      for (k = 0; k < gsz + 2; k++) begin
        chk("scan_chan", 32'(g0 + k % gsz), 32'(q_ch[k]));
        if (k > 0)
          chk("scan_period", 32'(SCAN_N[s % 4]), 32'(q_t[k] - q_t[k - 1]));
      end
      apb(1'b1, OFS_CSR, 32'(csel));
      for (k = 0; k < gsz; k++)
        rdchk(OFS_DATA + 8'(4 * (g0 + k)), lvl(g0 + k), 1'b0);
    end
    // Trigger sources: wrong ones ignored, the chosen one starts
    apb(1'b1, OFS_CSR, 32'h42);
    for (s = 0; s < 4; s++) begin
      apb(1'b1, OFS_MODE, 32'({2'(s), 4'b0011, 2'b00}));
      for (k = 1; k < 4; k++)
        if (k != s)
          fire(k);
      repeat (80) @(posedge pclk);
      rdchk(OFS_CSR, 32'h42, 1'b0);
      if (s > 0) begin
        fire(s);
        wait_end(n);
        rdchk(OFS_CSR, 32'hC2, 1'b0);
        rdchk(OFS_DATA + 8'h08, lvl(2), 1'b0);
        apb(1'b1, OFS_CSR, 32'h42);
      end
    end
    // Clock enable low freezes the sequencer, so the pause adds no states
    apb(1'b1, OFS_CSR, 32'h62);
    ce <= 1'b0;
    repeat (50) @(posedge pclk);
    ce <= 1'b1;
    wait_end(n);
    chk("frozen_time", 32'h1, 32'(n - 1 >= T_LO[3] && n - 1 <= T_HI[3]));
    rdchk(OFS_CSR, 32'hC2, 1'b0);
    // Reset after the finished run brings module stop back
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    rdchk(OFS_MSTOP, 32'h1, 1'b0);
    rdchk(OFS_CSR, 32'h0, 1'b1);
    close_out();
  end
endmodule // adc_sequencer_control_bench
